// [hdl/adc_out_pkg.sv]
// Constants shared by the converter sample output block
package adc_out_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W   = 15;
  localparam int unsigned MSB_POS  = 14;
  localparam int unsigned LSB_POS  = 0;
  localparam int unsigned LEVEL_W  = 16;
  localparam int unsigned DIFF_W   = LEVEL_W + 1;

  // ----------------------------------------------------------------------
  // Two's-complement full scale, expressed at the difference width and at the word width
  // ----------------------------------------------------------------------
  localparam logic signed [DIFF_W-1:0] CODE_MAX = 17'sh03fff;
  localparam logic signed [DIFF_W-1:0] CODE_MIN = -17'sh04000;
  localparam logic [WORD_W-1:0]        SAT_POS  = 15'h3fff;
  localparam logic [WORD_W-1:0]        SAT_NEG  = 15'h4000;

  // ----------------------------------------------------------------------
  // Pipeline and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned LATENCY   = 3;
  localparam logic [1:0]  FILL_DONE = 2'h3;
  localparam logic [1:0]  FILL_RST  = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 15'h0000;
  localparam logic        FLAG_RST  = 1'b0;

endpackage : adc_out_pkg

// [hdl/adc_parallel_sample_output.sv]
// Sample capture, latency pipeline and parallel output of the converter
//
// Summary of operation
// - One sample is captured on every rising edge of the differential clock.
// - Each result leaves as a 15-bit two's-complement word.
// - Output bit 0 is the LSB, output bit 14 the MSB.
// - Overrange flag is high when input leaves full scale, else low.
// - Valid strobe rises after the clock falling edge, usable as a clock.
// - Word is valid at strobe rise, three clock cycles after sampling.
// - Overrange flag is timed exactly like the sample word it qualifies.
module adc_parallel_sample_output (
  input  wire logic                                 ref_clk,
  input  wire logic                                 sys_rst,
  input  wire logic                                 clk_en,
  input  wire logic                                 conv_clock_pos,
  input  wire logic                                 conv_clock_neg,
  input  wire logic [adc_out_pkg::LEVEL_W-1:0]      analog_in_pos,
  input  wire logic [adc_out_pkg::LEVEL_W-1:0]      analog_in_neg,
  output logic      [adc_out_pkg::WORD_W-1:0]       sample_word,
  output logic                                      overrange_flag,
  output logic                                      sample_valid_strobe
);

  // ----------------------------------------------------------------------
  // Converter clock synchroniser and edge detect
  // ----------------------------------------------------------------------
  logic pos_meta;
  logic pos_sync;
  logic neg_meta;
  logic neg_sync;
  logic level_prev;

  // Differential level: high only while the positive leg leads. Only the
  // second flop of each leg is read, the first may still be settling.
  wire clk_level = pos_sync & ~neg_sync;
  wire rise_evt  = clk_en & clk_level & ~level_prev;
  wire fall_evt  = clk_en & ~clk_level & level_prev;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pos_meta   <= 1'b0;
      pos_sync   <= 1'b0;
      neg_meta   <= 1'b0;
      neg_sync   <= 1'b0;
      level_prev <= 1'b0;
    end else if (clk_en) begin
      pos_meta   <= conv_clock_pos;
      pos_sync   <= pos_meta;
      neg_meta   <= conv_clock_neg;
      neg_sync   <= neg_meta;
      level_prev <= clk_level;
    end
  end

  // ----------------------------------------------------------------------
  // Quantised difference, saturation and overrange
  // ----------------------------------------------------------------------
  wire logic signed [adc_out_pkg::DIFF_W-1:0] diff =
    $signed({1'b0, analog_in_pos}) - $signed({1'b0, analog_in_neg});
  wire over_hi = diff > adc_out_pkg::CODE_MAX;
  wire over_lo = diff < adc_out_pkg::CODE_MIN;
  wire over_in = over_hi | over_lo;
  // Clip to full scale so an overrange sample never wraps its sign
  wire logic [adc_out_pkg::WORD_W-1:0] sat_code =
    over_hi ? adc_out_pkg::SAT_POS :
    over_lo ? adc_out_pkg::SAT_NEG :
              diff[adc_out_pkg::WORD_W-1:0];

  // ----------------------------------------------------------------------
  // Latency pipeline, word and flag travel side by side
  // ----------------------------------------------------------------------
  logic [adc_out_pkg::WORD_W-1:0] pipe_code [adc_out_pkg::LATENCY];
  logic                           pipe_ovr  [adc_out_pkg::LATENCY];
  logic [1:0]                     fill;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pipe_code[0] <= adc_out_pkg::WORD_RST;
      pipe_ovr[0]  <= adc_out_pkg::FLAG_RST;
    end else if (rise_evt) begin
      pipe_code[0] <= sat_code;
      pipe_ovr[0]  <= over_in;
    end
  end

  genvar g;
  generate
    for (g = 1; g < adc_out_pkg::LATENCY; g++) begin : g_stage
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pipe_code[g] <= adc_out_pkg::WORD_RST;
          pipe_ovr[g]  <= adc_out_pkg::FLAG_RST;
        end else if (rise_evt) begin
          pipe_code[g] <= pipe_code[g-1];
          pipe_ovr[g]  <= pipe_ovr[g-1];
        end
      end
    end
  endgenerate

  // Counts rising edges until the pipeline holds a real sample
  wire filled = fill == adc_out_pkg::FILL_DONE;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fill <= adc_out_pkg::FILL_RST;
    end else if (rise_evt && !filled) begin
      fill <= fill + 2'h1;
    end
  end

  // The word in front of the first real sample is the reset value, so the
  // strobe waits for the rise that moves a real sample onto the pins
  logic word_live;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      word_live <= 1'b0;
    end else if (rise_evt && filled) begin
      word_live <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Output word, flag and strobe
  // ----------------------------------------------------------------------
  // Word and flag change only on a rising edge, strobe rises on the
  // falling edge, so the receiver sees half a period of setup.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sample_word    <= adc_out_pkg::WORD_RST;
      overrange_flag <= adc_out_pkg::FLAG_RST;
    end else if (rise_evt) begin
      sample_word    <= pipe_code[adc_out_pkg::LATENCY-1];
      overrange_flag <= pipe_ovr[adc_out_pkg::LATENCY-1];
    end
  end

  // No strobe until a sampled word has reached the pins
  // Falling with the word change keeps one strobe per converter period
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sample_valid_strobe <= 1'b0;
    end else if (fall_evt && word_live) begin
      sample_valid_strobe <= 1'b1;
    end else if (rise_evt) begin
      sample_valid_strobe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  capture_on_rise_a : assert property (
    rise_evt |=> pipe_code[0] == $past(sat_code))
    else $error("sample not captured on clock rising edge");

  in_range_code_a : assert property (
    !over_in |-> $signed(sat_code) == diff)
    else $error("in-range code differs from difference");

  msb_is_sign_a : assert property (
    sat_code[adc_out_pkg::MSB_POS] == diff[adc_out_pkg::DIFF_W-1])
    else $error("word msb does not carry the sign");

  overrange_flag_a : assert property (
    rise_evt |=> pipe_ovr[0] == ($past(diff) > adc_out_pkg::CODE_MAX ||
                                 $past(diff) < adc_out_pkg::CODE_MIN))
    else $error("overrange not flagged for an out-of-range sample");

  strobe_after_fall_a : assert property (
    $rose(sample_valid_strobe) |-> $past(fall_evt) && $past(word_live))
    else $error("strobe rose without a clock falling edge");

  three_edge_latency_a : assert property (
    rise_evt && filled ##1 (!rise_evt) [*1] |->
      sample_word == $past(pipe_code[adc_out_pkg::LATENCY-1], 2))
    else $error("word is not the sample three edges old");

  word_stable_strobe_a : assert property (
    $changed(sample_word) |-> $past(rise_evt) && !sample_valid_strobe)
    else $error("word changed while strobe high or off edge");

  flag_with_word_a : assert property (
    $changed(overrange_flag) |-> $past(rise_evt))
    else $error("overrange flag moved apart from the word");

  // ----------------------------------------------------------------------
  // Pairing, release and hold checks
  // ----------------------------------------------------------------------
  // A flagged word must be clipped, never a wrapped in-range value
  flag_saturates_a : assert property (
    overrange_flag |-> (sample_word == adc_out_pkg::SAT_POS ||
                        sample_word == adc_out_pkg::SAT_NEG))
    else $error("flagged word is not a full-scale code");

  strobe_needs_word_a : assert property (
    sample_valid_strobe |-> word_live)
    else $error("strobe high before a sample reached the pins");

  live_after_fill_a : assert property (
    $rose(word_live) |-> $past(rise_evt) && $past(filled))
    else $error("first word released before the pipeline filled");

  fill_holds_a : assert property (
    filled |=> filled)
    else $error("pipeline fill count left its full state");

  strobe_low_on_rise_a : assert property (
    rise_evt |=> !sample_valid_strobe)
    else $error("strobe still high after a clock rising edge");

  // Enable low must hold every output, including a strobe half way high
  enable_freeze_a : assert property (
    !clk_en |=> $stable(sample_word) && $stable(overrange_flag) &&
                $stable(sample_valid_strobe))
    else $error("outputs moved while the clock enable was low");

endmodule : adc_parallel_sample_output

// [verif/adc_parallel_sample_output_tb_top.sv]
// Bench for the converter sample output block
module adc_parallel_sample_output_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        conv_clock_pos = 1'b0;
  logic        conv_clock_neg = 1'b1;
  logic        conv_on = 1'b0;
  logic [15:0] analog_in_pos = 16'h8000;
  logic [15:0] analog_in_neg = 16'h8000;
  logic [14:0] sample_word;
  logic [14:0] rec_word;
  logic        overrange_flag;
  logic        sample_valid_strobe;
  logic        rec_flag;
  int          rec_cnt;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [15:0] exp_q[$];

  adc_parallel_sample_output i_adc_parallel_sample_output (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .conv_clock_pos(conv_clock_pos), .conv_clock_neg(conv_clock_neg),
    .analog_in_pos(analog_in_pos), .analog_in_neg(analog_in_neg),
    .sample_word(sample_word), .overrange_flag(overrange_flag),
    .sample_valid_strobe(sample_valid_strobe));
  capture_latch_model i_capture_latch_model (
    .sample_valid_strobe(sample_valid_strobe), .sample_word(sample_word),
    .overrange_flag(overrange_flag), .rec_word(rec_word),
    .rec_flag(rec_flag), .rec_cnt(rec_cnt));

  // --------------------------------------------------------------------
  // Clocks and expectations
  // --------------------------------------------------------------------
  always #2.5 ref_clk = ~ref_clk;
  // Odd start offset keeps converter edges off the system clock grid
  initial begin
    wait (conv_on);
    #1.3;
    forever begin
      #32;
      conv_clock_pos = ~conv_clock_pos;
      conv_clock_neg = ~conv_clock_neg;
    end
  end
  function automatic logic [15:0] exp_of(logic [15:0] p, logic [15:0] n);
    logic signed [16:0] d;
    d = $signed({1'b0, p}) - $signed({1'b0, n});
    if (d > adc_out_pkg::CODE_MAX) return {1'b1, adc_out_pkg::SAT_POS};
    if (d < adc_out_pkg::CODE_MIN) return {1'b1, adc_out_pkg::SAT_NEG};
    return {1'b0, d[14:0]};
  endfunction : exp_of
  always @(posedge conv_clock_pos) begin
    exp_q.push_back(exp_of(analog_in_pos, analog_in_neg));
  end
  always @(rec_cnt) begin
    if (rec_cnt > 0) begin
      check({rec_flag, rec_word}, exp_q.pop_front());
    end
  end
  always @(posedge sample_valid_strobe) begin
    check({15'h0000, conv_clock_pos}, 16'h0000);
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------------
  // Tasks and scenarios
  // --------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apply(input logic [15:0] p, input logic [15:0] n);
    @(negedge conv_clock_pos);
    @(negedge ref_clk);
    analog_in_pos = p;
    analog_in_neg = n;
  endtask : apply
  task automatic in_range_edges();
    apply(16'h8001, 16'h8000);
    apply(16'h8000, 16'h8001);
    apply(16'hbfff, 16'h8000);
    apply(16'h4000, 16'h8000);
    repeat (6) @(posedge conv_clock_pos);
  endtask : in_range_edges
  // Over and in range back to back: each flag must stay with its word
  task automatic overrange_cases();
    apply(16'hc000, 16'h8000);
    apply(16'h8000, 16'h8000);
    apply(16'h3fff, 16'h8000);
    apply(16'hffff, 16'h0000);
    apply(16'h0000, 16'hffff);
    repeat (6) @(posedge conv_clock_pos);
  endtask : overrange_cases
  task automatic bit_order();
    for (int i = 0; i < 14; i++) begin
      apply(16'h8000 + (16'h0001 << i), 16'h8000);
    end
    apply(16'h4000, 16'h8000);
    repeat (6) @(posedge conv_clock_pos);
  endtask : bit_order
  // Enable held low across a converter rising edge: word and strobe hold
  task automatic freeze_hold();
    logic [15:0] held;
    @(posedge sample_valid_strobe);
    @(negedge ref_clk);
    held = {overrange_flag, sample_word};
    clk_en = 1'b0;
    repeat (7) @(negedge ref_clk);
    check({overrange_flag, sample_word}, held);
    check({15'h0000, sample_valid_strobe}, 16'h0001);
    clk_en = 1'b1;
    repeat (4) @(posedge conv_clock_pos);
  endtask : freeze_hold
  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    check({overrange_flag, sample_word}, 16'h0000);
    check({15'h0000, sample_valid_strobe}, 16'h0000);
    conv_on = 1'b1;
    in_range_edges();
    overrange_cases();
    freeze_hold();
    bit_order();
    report_and_stop();
  end
endmodule : adc_parallel_sample_output_tb_top

// [verif/capture_latch_model.sv]
// Receiver model: capture latch clocked by the valid strobe
module capture_latch_model (
  input  wire logic        sample_valid_strobe,
  input  wire logic [14:0] sample_word,
  input  wire logic        overrange_flag,
  output logic      [14:0] rec_word,
  output logic             rec_flag,
  output int               rec_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  // Word and flag taken as one record, one per strobe rise
  always @(posedge sample_valid_strobe) begin
    rec_word <= sample_word;
    rec_flag <= overrange_flag;
    rec_cnt  <= rec_cnt + 1;
  end
endmodule : capture_latch_model
